// [logic/wdwr_consts.vh]
`ifndef WDWR_CONSTS_VH
`define WDWR_CONSTS_VH

// Register byte offsets
`define WDWR_OFS_CTRL_ZERO      8'h00
`define WDWR_OFS_CLK_WIN        8'h04
`define WDWR_OFS_PS_LOW         8'h08
`define WDWR_OFS_PS_HIGH        8'h0C
`define WDWR_OFS_TIMER          8'h10
`define WDWR_OFS_IRQ_STATUS     8'h14
`define WDWR_OFS_IRQ_CLEAR      8'h18
`define WDWR_OFS_IRQ_ENABLE     8'h1C
`define WDWR_OFS_RESET_CAUSE    8'h20

// Clock and window control fields
`define WDWR_CS_LSB             4
`define WDWR_CS_MSB             6
`define WDWR_WIN_LSB            0
`define WDWR_WIN_MSB            2

// Timer register fields
`define WDWR_TMR_PS_LSB         0
`define WDWR_TMR_PS_MSB         1
`define WDWR_TMR_ARMED_BIT      2
`define WDWR_TMR_CNT_LSB        3
`define WDWR_TMR_CNT_MSB        6

// Interrupt status bits
`define WDWR_IRQ_TIMEOUT_BIT    0
`define WDWR_IRQ_VIOLATION_BIT  1

// Encodings and reset values
`define WDWR_CS_LOW_FREQ        3'h0
`define WDWR_CS_MID_FREQ_DIV16  3'h1
`define WDWR_SEL_SOFTWARE       3'h7
`define WDWR_WIN_FULL_OPEN      3'h7
`define WDWR_CS_RESET           3'h0
`define WDWR_PS_RESET           18'h00000
`define WDWR_CNT_RESET          4'h0
`define WDWR_FLAG_N_RESET       1'b1

// Cycles to wait for synchronised straps after reset
`define WDWR_INIT_CYCLES        2'h3

`endif

// [logic/wdwr_top.v]
// Function
// - The clock source field picks the low-frequency oscillator at 000, the mid oscillator undivided at 001, and no timebase for reserved codes.
// - The window field sets a closed delay of (7 - code) eighths of the period, so 111 is fully open and 000 opens only the last eighth.
// - With the configuration clock select at 111 the register clock source field resets to 000.
// - The clock source field ignores writes whenever the configuration clock select is not 111.
// - After reset the window field is loaded from the configuration window select.
// - The 18-bit prescale count is shown as a low byte, a high byte and two bits of the timer register.
// - Prescale bits 17:16 read in timer register bits 1:0.
// - The four-bit watchdog count reads in timer register bits 6:3 and resets to zero.
// - Timer register bit 2 reads 1 while the watchdog is armed.
// - Bits 7 and 3 of the clock and window control register read as zero.
// - The prescale byte registers are read-only, reset to zero and ignore writes.
// - In windowed mode a clear while the window is closed is a violation that resets the device.
// - In windowed mode a clear without a prior read of control register zero is a violation.
// - The counter is cleared on reset, a valid clear, sleep entry or exit, disable, start-up timer running and any control register write.
// - A violation requests a reset and clears the active-low violation flag, which reset sets and firmware may set.
`timescale 1ns/10ps
`include "wdwr_consts.vh"

module wdwr_top #(
    parameter PS_WIDTH  = 18,
    parameter CNT_WIDTH = 4
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  cfg_clock_source_select,
    input  wire [2:0]  cfg_window_size_select,
    input  wire        low_freq_internal_osc,
    input  wire        mid_freq_internal_osc,
    input  wire        clear_instruction,
    input  wire        sleep_enter,
    input  wire        sleep_exit,
    input  wire        wd_disabled,
    input  wire        ost_running,
    output reg         wd_reset_req,
    output reg         irq
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Window is closed while count is below twice the delay in eighths
    function win_closed;
        input [2:0] win;
        input [3:0] cnt;
        reg   [3:0] limit;
        begin
            limit      = {(3'h7 - win), 1'b0};
            win_closed = (cnt < limit);
        end
    endfunction

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    reg  [2:0] ccs_meta;
    reg  [2:0] ccs_sync;
    reg  [2:0] cws_meta;
    reg  [2:0] cws_sync;
    reg  [1:0] osc_meta;
    reg  [1:0] osc_sync;
    reg  [1:0] osc_prev;

    // Straps and oscillators come from outside this clock
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ccs_meta <= 3'h0;
            ccs_sync <= 3'h0;
            cws_meta <= 3'h0;
            cws_sync <= 3'h0;
            osc_meta <= 2'h0;
            osc_sync <= 2'h0;
            osc_prev <= 2'h0;
        end else begin
            ccs_meta <= cfg_clock_source_select;
            ccs_sync <= ccs_meta;
            cws_meta <= cfg_window_size_select;
            cws_sync <= cws_meta;
            osc_meta <= {mid_freq_internal_osc, low_freq_internal_osc};
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire       acc      = psel & penable & pready;
    wire       wr_acc   = acc & pwrite;
    wire       rd_acc   = acc & ~pwrite;
    wire       hit_ctrl0 = (paddr == `WDWR_OFS_CTRL_ZERO);
    wire       hit_cw   = (paddr == `WDWR_OFS_CLK_WIN);
    wire       wr_ctrl  = wr_acc & (hit_ctrl0 | hit_cw);
    wire       ccs_soft = (ccs_sync == `WDWR_SEL_SOFTWARE);
    wire       cws_soft = (cws_sync == `WDWR_SEL_SOFTWARE);

    // ------------------------------------------------------------
    // Clock and window control
    // ------------------------------------------------------------
    reg  [2:0] clock_source_select;
    reg  [2:0] window_select;
    reg  [1:0] init_cnt;
    wire       init_done = (init_cnt == `WDWR_INIT_CYCLES);

    // Straps are only trusted once the synchronisers have filled
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_source_select <= `WDWR_CS_RESET;
            window_select       <= `WDWR_WIN_FULL_OPEN;
            init_cnt            <= 2'h0;
        end else if (!init_done) begin
            init_cnt <= init_cnt + 2'h1;
            if (init_cnt == (`WDWR_INIT_CYCLES - 2'h1)) begin
                clock_source_select <= ccs_soft ? `WDWR_CS_RESET : ccs_sync;
                window_select       <= cws_sync;
            end
        end else begin
            if (wr_acc && hit_cw && ccs_soft) begin
                clock_source_select <= pwdata[`WDWR_CS_MSB:`WDWR_CS_LSB];
            end else if (!ccs_soft) begin
                clock_source_select <= ccs_sync;
            end
            if (wr_acc && hit_cw && cws_soft) begin
                window_select <= pwdata[`WDWR_WIN_MSB:`WDWR_WIN_LSB];
            end else if (!cws_soft) begin
                window_select <= cws_sync;
            end
        end
    end

    // ------------------------------------------------------------
    // Timebase selection
    // ------------------------------------------------------------
    reg tick;

    // Rising edge of the selected oscillator; reserved codes stop the timer
    always @* begin
        case (clock_source_select)
            `WDWR_CS_LOW_FREQ:       tick = osc_sync[0] & ~osc_prev[0];
            `WDWR_CS_MID_FREQ_DIV16: tick = osc_sync[1] & ~osc_prev[1];
            default:                 tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Prescale and watchdog counters
    // ------------------------------------------------------------
    reg  [PS_WIDTH-1:0]  prescale_count;
    reg  [CNT_WIDTH-1:0] count_value;
    reg                  armed;
    wire windowed   = (window_select != `WDWR_WIN_FULL_OPEN);
    wire violation  = clear_instruction & windowed &
                      (win_closed(window_select, count_value) | ~armed);
    wire valid_clr  = clear_instruction & ~violation;
    wire cnt_clear  = valid_clr | sleep_enter | sleep_exit | wd_disabled |
                      ost_running | wr_ctrl;
    wire ps_wrap    = tick & (&prescale_count);
    wire timeout    = ps_wrap & (&count_value);

    // Counter advances one prescale period per count step
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale_count <= `WDWR_PS_RESET;
            count_value    <= `WDWR_CNT_RESET;
        end else if (cnt_clear || violation || timeout) begin
            prescale_count <= `WDWR_PS_RESET;
            count_value    <= `WDWR_CNT_RESET;
        end else if (tick) begin
            prescale_count <= prescale_count + 1'b1;
            if (ps_wrap) begin
                count_value <= count_value + 1'b1;
            end
        end
    end

    // Arming by reading control register zero; any clear disarms
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (clear_instruction) begin
            armed <= 1'b0;
        end else if (rd_acc && hit_ctrl0) begin
            armed <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset request and violation flag
    // ------------------------------------------------------------
    reg window_violation_flag_n;

    // Violation clears the flag; hardware clear beats firmware set
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_reset_req            <= 1'b0;
            window_violation_flag_n <= `WDWR_FLAG_N_RESET;
        end else begin
            wd_reset_req <= violation | timeout;
            if (violation) begin
                window_violation_flag_n <= 1'b0;
            end else if (wr_acc && (paddr == `WDWR_OFS_RESET_CAUSE) && pwdata[0]) begin
                window_violation_flag_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    reg  [1:0] irq_status;
    reg  [1:0] irq_enable;
    wire [1:0] irq_events = {violation, timeout};
    wire [1:0] irq_clr    = (wr_acc && (paddr == `WDWR_OFS_IRQ_CLEAR)) ? pwdata[1:0] : 2'h0;

    // Set wins over a same-cycle clear so no event is lost
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_events;
            if (wr_acc && (paddr == `WDWR_OFS_IRQ_ENABLE)) begin
                irq_enable <= pwdata[1:0];
            end
            irq <= |(((irq_status & ~irq_clr) | irq_events) & irq_enable);
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    reg [31:0] next_prdata;
    reg        next_slverr;

    // Live snapshot of counters at the read; unused bits read zero
    always @* begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        case (paddr)
            `WDWR_OFS_CTRL_ZERO: begin
                next_prdata = 32'h00000000;
            end
            `WDWR_OFS_CLK_WIN: begin
                next_prdata[`WDWR_CS_MSB:`WDWR_CS_LSB]   = clock_source_select;
                next_prdata[`WDWR_WIN_MSB:`WDWR_WIN_LSB] = window_select;
            end
            `WDWR_OFS_PS_LOW: begin
                next_prdata[7:0] = prescale_count[7:0];
            end
            `WDWR_OFS_PS_HIGH: begin
                next_prdata[7:0] = prescale_count[15:8];
            end
            `WDWR_OFS_TIMER: begin
                next_prdata[`WDWR_TMR_PS_MSB:`WDWR_TMR_PS_LSB]   = prescale_count[17:16];
                next_prdata[`WDWR_TMR_ARMED_BIT]                 = armed;
                next_prdata[`WDWR_TMR_CNT_MSB:`WDWR_TMR_CNT_LSB] = count_value;
            end
            `WDWR_OFS_IRQ_STATUS: begin
                next_prdata[1:0] = irq_status;
            end
            `WDWR_OFS_IRQ_CLEAR: begin
                next_prdata = 32'h00000000;
            end
            `WDWR_OFS_IRQ_ENABLE: begin
                next_prdata[1:0] = irq_enable;
            end
            `WDWR_OFS_RESET_CAUSE: begin
                next_prdata[0] = window_violation_flag_n;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One wait state keeps prdata registered and glitch free
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= next_slverr;
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

endmodule

// [verification/wdwr_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the watchdog registers
// ----------------------------------------
module wdwr_properties #(
    parameter PS_WIDTH  = 18,
    parameter CNT_WIDTH = 4
) (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire [2:0]  cfg_clock_source_select,
    input wire [2:0]  cfg_window_size_select,
    input wire        clear_instruction,
    input wire        wd_disabled,
    input wire        wd_reset_req,
    input wire        irq
);
    reg  [2:0] cs_q;
    reg  [2:0] ws_q;
    reg  [2:0] quiet;
    reg        armed_h;
    wire       rd_done = pready && !pwrite;
    wire       settled = quiet == 3'h7;

    // Straps pass a synchroniser, so judge them only once quiet
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_q    <= 3'h0;
            ws_q    <= 3'h0;
            quiet   <= 3'h0;
            armed_h <= 1'b0;
        end else begin
            cs_q <= cfg_clock_source_select;
            ws_q <= cfg_window_size_select;
            if (cs_q != cfg_clock_source_select || ws_q != cfg_window_size_select)
                quiet <= 3'h0;
            else if (quiet != 3'h7)
                quiet <= quiet + 3'h1;
            if (clear_instruction)
                armed_h <= 1'b0;
            else if (rd_done && paddr == 8'h00)
                armed_h <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ready_answer_a : assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    ctrl_unused_zero_a : assert property (
        rd_done && paddr == 8'h04 |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("unused control bits read as one");
    src_locked_a : assert property (
        rd_done && paddr == 8'h04 && settled && cfg_clock_source_select != 3'h7
        |-> prdata[6:4] == cfg_clock_source_select) else $error("source not locked");
    win_locked_a : assert property (
        rd_done && paddr == 8'h04 && settled && cfg_window_size_select != 3'h7
        |-> prdata[2:0] == cfg_window_size_select) else $error("window not locked");
    armed_view_a : assert property (
        rd_done && paddr == 8'h10 |-> prdata[2] == armed_h) else $error("armed flag wrong");
    ps_held_a : assert property (
        rd_done && paddr == 8'h08 && wd_disabled && $past(wd_disabled)
        && $past(wd_disabled, 2) |-> prdata == 32'h0) else $error("prescale not held");
    unarmed_clear_a : assert property (
        settled && cfg_window_size_select != 3'h7 && clear_instruction && !armed_h
        && !wd_disabled |-> ##[1:2] wd_reset_req) else $error("no violation reset");
    reset_pulse_a : assert property (wd_reset_req |=> !wd_reset_req)
        else $error("reset request longer than one cycle");

    cover property (rd_done && paddr == 8'h00);
    cover property (wd_reset_req);
    cover property (irq);
endmodule

bind wdwr_top wdwr_properties #(.PS_WIDTH(PS_WIDTH), .CNT_WIDTH(CNT_WIDTH))
    wdwr_properties_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready),
    .cfg_clock_source_select(cfg_clock_source_select),
    .cfg_window_size_select(cfg_window_size_select),
    .clear_instruction(clear_instruction), .wd_disabled(wd_disabled),
    .wd_reset_req(wd_reset_req), .irq(irq)
);

// [verification/wdwr_core_model.sv]
`timescale 1ns/10ps
// ---------------------------------------
// Core side: clear issued after a delay
// ---------------------------------------
module wdwr_core_model (
    input wire       clk,
    input wire       rst,
    input wire       go,
    input wire [3:0] delay,
    output reg       clear_instruction
);
    reg [4:0] wait_cnt;

    // Delay lets the core answer promptly or slowly
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt          <= 5'h00;
            clear_instruction <= 1'b0;
        end else begin
            clear_instruction <= wait_cnt == 5'h01;
            if (go)
                wait_cnt <= {1'b0, delay} + 5'h01;
            else if (wait_cnt != 5'h00)
                wait_cnt <= wait_cnt - 5'h01;
        end
    end
endmodule

// [verification/wdwr_top_test.sv]
`timescale 1ns/10ps
// ----------------------------------
// Bench for the watchdog registers
// ----------------------------------
module wdwr_top_test;
    reg         clk         = 1'b0;
    reg         rst         = 1'b1;
    reg         psel        = 1'b0;
    reg         penable     = 1'b0;
    reg         pwrite      = 1'b0;
    reg  [7:0]  paddr       = 8'h00;
    reg  [31:0] pwdata      = 32'h0;
    reg  [2:0]  cfg_cs      = 3'h7;
    reg  [2:0]  cfg_ws      = 3'h5;
    reg         lf_osc      = 1'b0;
    reg         mf_osc      = 1'b0;
    reg         go          = 1'b0;
    reg  [3:0]  delay       = 4'h0;
    reg         sleep_enter = 1'b0;
    reg         wd_disabled = 1'b0;
    reg  [31:0] rdata;
    reg         err;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        clear_instruction;
    wire        wd_reset_req;
    wire        irq;
    integer     n_errors    = 0;
    integer     tests_run   = 0;

    wdwr_top wdwr_top_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_clock_source_select(cfg_cs),
        .cfg_window_size_select(cfg_ws), .low_freq_internal_osc(lf_osc),
        .mid_freq_internal_osc(mf_osc), .clear_instruction(clear_instruction),
        .sleep_enter(sleep_enter), .sleep_exit(1'b0), .wd_disabled(wd_disabled),
        .ost_running(1'b0), .wd_reset_req(wd_reset_req), .irq(irq));
    wdwr_core_model wdwr_core_model_inst (.clk(clk), .rst(rst), .go(go),
        .delay(delay), .clear_instruction(clear_instruction));

    // 250 MHz clock
    always #2 clk = ~clk;

    task test_done;
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; held until pready is seen at an edge
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input [7:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // Oscillator pulses; slow enough for the synchroniser
    task osc(input sel, input integer n);
        repeat (n) begin
            {mf_osc, lf_osc} <= sel ? 2'b10 : 2'b01;
            repeat (4) @(posedge clk);
            {mf_osc, lf_osc} <= 2'b00;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    // Core clears; watch for a reset request
    task clr(input [3:0] dl, input exp);
        reg seen;
        seen = 1'b0;
        go    <= 1'b1;
        delay <= dl;
        @(posedge clk);
        go <= 1'b0;
        repeat (24) begin
            @(posedge clk);
            if (wd_reset_req === 1'b1)
                seen = 1'b1;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    task t_reset;
        rd(8'h04, 32'h05);
        rd(8'h10, 32'h00);
        rd(8'h0C, 32'h00);
        rd(8'h20, 32'h01);
    endtask

    task t_lock;
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'h75);
        cfg_cs <= 3'h2;
        repeat (10) @(posedge clk);
        wr(8'h04, 32'h00);
        rd(8'h04, 32'h25);
        cfg_cs <= 3'h7;
        repeat (10) @(posedge clk);
    endtask

    task t_count;
        wr(8'h04, 32'h05);
        osc(1'b0, 261);
        osc(1'b1, 3);
        rd(8'h08, 32'h05);
        rd(8'h0C, 32'h01);
        wr(8'h04, 32'h15);
        osc(1'b1, 3);
        osc(1'b0, 2);
        rd(8'h08, 32'h03);
        wr(8'h04, 32'h25);
        osc(1'b0, 2);
        osc(1'b1, 2);
        rd(8'h08, 32'h00);
        wr(8'h08, 32'hFF);
        wr(8'h0C, 32'hFF);
        rd(8'h08, 32'h00);
        rd(8'h0C, 32'h00);
    endtask

    task t_viol;
        wr(8'h1C, 32'h03);
        rd(8'h00, 32'h00);
        rd(8'h10, 32'h04);
        clr(4'h0, 1'b1);
        rd(8'h10, 32'h00);
        rd(8'h20, 32'h00);
        rd(8'h14, 32'h02);
        chk({31'h0, irq}, 32'h1);
        wr(8'h18, 32'h03);
        rd(8'h14, 32'h00);
        chk({31'h0, irq}, 32'h0);
        wr(8'h1C, 32'h00);
        clr(4'h5, 1'b1);
        rd(8'h14, 32'h02);
        chk({31'h0, irq}, 32'h0);
        wr(8'h18, 32'h03);
        wr(8'h20, 32'h01);
        rd(8'h20, 32'h01);
    endtask

    task t_open;
        cfg_ws <= 3'h7;
        repeat (10) @(posedge clk);
        wr(8'h04, 32'h07);
        rd(8'h04, 32'h07);
        clr(4'h2, 1'b0);
        rd(8'h14, 32'h00);
    endtask

    task t_hold;
        wd_disabled <= 1'b1;
        osc(1'b0, 3);
        rd(8'h08, 32'h00);
        wd_disabled <= 1'b0;
        osc(1'b0, 3);
        rd(8'h08, 32'h03);
        sleep_enter <= 1'b1;
        @(posedge clk);
        sleep_enter <= 1'b0;
        rd(8'h08, 32'h00);
        osc(1'b0, 2);
        wr(8'h00, 32'h00);
        rd(8'h08, 32'h00);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset;
        t_lock;
        t_count;
        t_viol;
        t_open;
        t_hold;
        test_done;
    end

    // Cuts a hang; the normal run is near 2600 cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_errors = n_errors + 1;
        test_done;
    end
endmodule
